/* hw/led_dim_defines.svh */
// Offsets, field positions, reset values and timing counts of the dimming engine
// What this block does
// - Dimming period from the oscillator, eight frequencies 76 Hz to 9766 Hz.
// - Phase-shift and hybrid periods run free of the input PWM period.
// - Resolution 16 bits at 76 and 153 Hz, one bit less per doubling.
// - Phase-shift mode: active groups switch at dimming rate, fixed neighbour delay.
// - Neighbour offset is one period over the active group count.
// - Hybrid: PWM at low, current level at high, threshold 12.5% or 0%.
// - Hybrid extends the dimming ratio eight times over pure PWM.
// - Direct mode: active channels follow the PWM input pin.
// - After reset the curved sloper is on with a 200 ms ramp.
// - Three-bit slope time field; zero disables the sloper.
// - Curved ramp enable adds smoothing beyond the linear ramp.
// - PWM input on-time is accepted only when it moves more than 6.4 us.
// - Without dither, brightness steps equal clocks per dimming period, except at 76 Hz, where they are half the clocks.
// - Four-bit dither field: off or 1 to 4 extra bits; off after reset.
// - One-bit dither lengthens every second pulse by one clock.
// - Three-bit dither lengthens that many pulses out of every eight.
// - Pulses below 200 ns become minimum pulses with some periods skipped.
// - Pulse repetition never falls below 76 Hz while skipping.
// - Source select: PWM input or register value; PWM input after reset.
// - Mode is phase-shift, hybrid, current or direct, sampled at init.
// - Missing frequency setting falls back to 153 Hz and stays there.
`ifndef LED_DIM_DEFINES_SVH
`define LED_DIM_DEFINES_SVH
`define CLK_HZ 10000000
`define ADR_CTRL 4'h0
`define ADR_BRIGHT 4'h4
`define ADR_STATUS 4'h8
`define ADR_CONFIG 4'hC
`define CTRL_SRC 0
`define CTRL_CURVED 1
`define CTRL_SLOPE_LO 2
`define CTRL_DITHER_LO 5
`define CTRL_HYB_ZERO 9
`define SLOPE_RESET 3'h3
`define DITHER_RESET 4'h0
`define FREQ_FALLBACK 3'h1
`define SLOPE_BASE_LOG 5
`define SLOPE_DEFAULT_MS 200
`define SLOPE_TICK_CYC_DEF ((`SLOPE_DEFAULT_MS * (`CLK_HZ / 1000)) / 256)
`define HYST_NS 6400
`define HYST_CYC ((`HYST_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define MIN_PULSE_NS 200
`define MIN_PULSE_CYC ((`MIN_PULSE_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define HYB_THRESHOLD 16'h2000
`define HYB_PWM_CURRENT 12'h200
`endif

/* hw/led_dim_pkg.sv */
// Types shared by the dimming engine and its users
package led_dim_pkg;
   typedef enum logic [1:0] {MODE_PHASE, MODE_HYBRID, MODE_CURRENT, MODE_DIRECT} dim_mode_t;
   typedef enum logic {ST_INIT, ST_RUN} run_state_t;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;
   typedef struct packed {
      logic [1:0] mode;
      logic mode_ok;
      logic [2:0] freq;
      logic freq_ok;
      logic [2:0] grouping;
      logic grouping_ok;
   } strap_t;
   typedef struct packed {
      run_state_t st;
      dim_mode_t mode;
      logic [2:0] fsel;
      logic [2:0] grp;
      logic [2:0] faults;
      logic [16:0] cnt;
      logic pin_q;
      logic [19:0] hi_cnt;
      logic [19:0] per_cnt;
      logic [19:0] last_on;
      logic div_busy;
      logic [4:0] div_step;
      logic [20:0] div_rem;
      logic [19:0] div_per;
      logic [15:0] div_q;
      logic [15:0] pwm_duty;
      logic src_reg;
      logic curved;
      logic [2:0] slope_sel;
      logic [3:0] dither_sel;
      logic hyb_zero;
      logic [15:0] bright_reg;
      logic [15:0] target;
      logic dir;
      logic [31:0] lin;
      logic [31:0] delta;
      logic [12:0] ticks_left;
      logic [15:0] tick_cnt;
      logic [15:0] level;
      logic [17:0] on_len;
      logic [3:0] dacc;
      logic [17:0] skip_acc;
      logic [7:0] skip_per;
      logic [5:0][16:0] phase;
      logic [5:0] chan_en;
      logic [11:0] cur_lvl;
      logic ack;
      logic [31:0] rdat;
   } state_t;
endpackage

/* hw/led_dim_engine.sv */
// Dimming engine: period generator, sloper, dither, phase shift, Wishbone registers
//
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
`include "led_dim_defines.svh"
module led_dim_engine #(
   parameter int SLOPE_TICK_CYC = `SLOPE_TICK_CYC_DEF
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire led_dim_pkg::wb_req_t wb_req,
   output logic wb_ack,
   output logic [31:0] wb_dat_o,
   input wire led_dim_pkg::strap_t strap,
   input wire logic pwm_in,
   output logic [5:0] channel_enable,
   output logic [11:0] current_level
);
   import led_dim_pkg::*;

   localparam logic [19:0] HYST = 20'(`HYST_CYC);
   localparam logic [17:0] MINP = 18'(`MIN_PULSE_CYC);
   localparam logic [15:0] TICK_LAST = 16'(SLOPE_TICK_CYC - 1);

   // Elaboration check on the shortened tick
   if (SLOPE_TICK_CYC < 1 || SLOPE_TICK_CYC > 65536) begin : bad_tick
      $error("SLOPE_TICK_CYC out of range");
   end

   // Active group count per grouping code
   function automatic logic [2:0] groups_of(input logic [2:0] g);
      case (g)
         3'd0: groups_of = 3'd6;
         3'd1: groups_of = 3'd5;
         3'd2: groups_of = 3'd4;
         3'd3: groups_of = 3'd3;
         3'd4: groups_of = 3'd2;
         3'd5: groups_of = 3'd3;
         3'd6: groups_of = 3'd2;
         default: groups_of = 3'd1;
      endcase
   endfunction

   // Group that drives channel c; tied channels share a group
   function automatic logic [2:0] group_of(input logic [2:0] g, input logic [2:0] c);
      case (g)
         3'd5: group_of = 3'(c >> 1);
         3'd6: group_of = (c > 3'd2) ? 3'd1 : 3'd0;
         3'd7: group_of = 3'd0;
         default: group_of = c;
      endcase
   endfunction

   function automatic logic used_of(input logic [2:0] g, input logic [2:0] c);
      used_of = (g > 3'd4) || (c < groups_of(g));
   endfunction

   state_t s;
   state_t n;
   logic [16:0] plen_m1;
   logic [15:0] pduty;
   logic [11:0] cur;
   logic [20:0] w;
   logic [17:0] base;
   logic [3:0] frac;
   logic [4:0] dsum;
   logic [3:0] dmask;
   logic [2:0] dbits;
   logic [17:0] req;
   logic [15:0] new_tgt;
   logic [15:0] lin16;
   logic [16:0] diff;
   logic [3:0] k;
   logic [16:0] pos;
   logic [19:0] ond;
   logic [16:0] lvl_diff;
   logic [31:0] wm;

   always_comb begin
      n = s;
      plen_m1 = 17'h1FFFF >> s.fsel;
      pduty = 16'h0;
      cur = 12'hFFF;
      w = 21'h0;
      base = 18'h0;
      frac = 4'h0;
      dsum = 5'h0;
      dmask = 4'h0;
      dbits = 3'h0;
      req = 18'h0;
      new_tgt = 16'h0;
      lin16 = s.lin[31:16];
      diff = 17'h0;
      k = 4'h0;
      pos = 17'h0;
      ond = 20'h0;
      lvl_diff = 17'h0;
      wm = 32'h0;

      // Straps are caught once, at the first enabled cycle after reset
      if (s.st == ST_INIT) begin
         n.st = ST_RUN;
         n.mode = strap.mode_ok ? dim_mode_t'(strap.mode) : MODE_PHASE;
         n.fsel = strap.freq_ok ? strap.freq : `FREQ_FALLBACK;
         n.grp = strap.grouping_ok ? strap.grouping : 3'd0;
         n.faults = {~strap.grouping_ok, ~strap.mode_ok, ~strap.freq_ok};
      end

      // Period counter, free running against the input PWM
      if (s.st == ST_RUN) begin
         n.cnt = (s.cnt >= plen_m1) ? 17'h0 : 17'(s.cnt + 17'h1);
      end

      // Phase of each group, one period over the group count
      if (s.st == ST_INIT) begin
         for (int g = 0; g < 6; g++) begin
            n.phase[g] = 17'(((g * 131072) / groups_of(n.grp)) >> n.fsel);
         end
      end

      // Input measurement; counters saturate when the pin stands still
      n.pin_q = pwm_in;
      n.hi_cnt = (s.hi_cnt == 20'hFFFFF) ? s.hi_cnt : 20'(s.hi_cnt + {19'h0, pwm_in});
      n.per_cnt = (s.per_cnt == 20'hFFFFF) ? s.per_cnt : 20'(s.per_cnt + 20'h1);
      if (pwm_in && !s.pin_q) begin
         // The rising cycle is already a high clock, counted like the period
         n.hi_cnt = 20'h1;
         n.per_cnt = 20'h1;
         ond = (s.hi_cnt > s.last_on) ? 20'(s.hi_cnt - s.last_on) : 20'(s.last_on - s.hi_cnt);
         if (ond > HYST && !s.div_busy && s.per_cnt != 20'h0) begin
            n.last_on = s.hi_cnt;
            n.div_busy = 1'b1;
            n.div_step = 5'd0;
            n.div_rem = {1'b0, s.hi_cnt};
            n.div_per = s.per_cnt;
            n.div_q = 16'h0;
         end
      end else if (s.per_cnt == 20'hFFFFE) begin
         n.pwm_duty = pwm_in ? 16'hFFFF : 16'h0;
         n.last_on = pwm_in ? 20'hFFFFF : 20'h0;
      end

      // Restoring divider: duty = on-time * 2^16 / period
      if (s.div_busy) begin
         if (s.div_step == 5'd16) begin
            n.div_busy = 1'b0;
            n.pwm_duty = (s.div_rem >= {1'b0, s.div_per}) ? 16'hFFFF : s.div_q;
         end else begin
            n.div_rem = {s.div_rem[19:0], 1'b0};
            n.div_q = {s.div_q[14:0], 1'b0};
            if (n.div_rem >= {1'b0, s.div_per}) begin
               n.div_rem = 21'(n.div_rem - {1'b0, s.div_per});
               n.div_q[0] = 1'b1;
            end
            n.div_step = 5'(s.div_step + 5'd1);
         end
      end

      // Sloper: linear ramp in 16.16, optional smoothing stage after it
      new_tgt = s.src_reg ? s.bright_reg : s.pwm_duty;
      k = 4'({1'b0, s.slope_sel} + 4'(`SLOPE_BASE_LOG)); // Widened so select 7 cannot wrap
      if (s.slope_sel == 3'h0) begin
         n.target = new_tgt;
         n.lin = {new_tgt, 16'h0};
         n.ticks_left = 13'h0;
         n.level = new_tgt;
      end else if (new_tgt != s.target) begin
         diff = (new_tgt > lin16) ? 17'(new_tgt - lin16) : 17'(lin16 - new_tgt);
         n.target = new_tgt;
         n.dir = new_tgt > lin16;
         n.delta = ({15'h0, diff} << 16) >> k;
         n.ticks_left = 13'h1 << k;
      end else begin
         n.tick_cnt = (s.tick_cnt == TICK_LAST) ? 16'h0 : 16'(s.tick_cnt + 16'h1);
         if (s.tick_cnt == TICK_LAST) begin
            if (s.ticks_left == 13'h1) begin
               n.lin = {s.target, 16'h0};
            end else if (s.ticks_left != 13'h0) begin
               n.lin = s.dir ? 32'(s.lin + s.delta) : 32'(s.lin - s.delta);
            end
            n.ticks_left = (s.ticks_left != 13'h0) ? 13'(s.ticks_left - 13'h1) : 13'h0;
            lvl_diff = 17'({1'b0, n.lin[31:16]} - {1'b0, s.level});
            if (!s.curved || lvl_diff[16:2] == 15'h0 || lvl_diff[16:2] == 15'h7FFF) begin
               n.level = n.lin[31:16];
            end else begin
               n.level = 16'(s.level + {{2{lvl_diff[16]}}, lvl_diff[15:2]});
            end
         end
      end

      // Mode split between pulse width and current level
      case (s.mode)
         MODE_HYBRID: begin
            if (!s.hyb_zero && s.level < `HYB_THRESHOLD) begin
               pduty = {s.level[12:0], 3'h0};
               cur = `HYB_PWM_CURRENT;
            end else begin
               pduty = (s.level == 16'h0) ? 16'h0 : 16'hFFFF;
               cur = s.level[15:4];
            end
         end
         MODE_CURRENT: begin
            pduty = (s.level == 16'h0) ? 16'h0 : 16'hFFFF;
            cur = s.level[15:4];
         end
         default: begin
            pduty = s.level;
            cur = 12'hFFF;
         end
      endcase

      // Pulse width, dither and skipping, settled once per period
      w = {pduty, 5'h0} >> s.fsel;
      base = (pduty == 16'hFFFF) ? 18'({1'b0, plen_m1} + 18'h1) : {1'b0, w[20:4]};
      dbits = (s.dither_sel > 4'd4) ? 3'd0 : s.dither_sel[2:0];
      dmask = 4'((5'h1 << dbits) - 5'h1);
      frac = 4'(w[3:0] >> (3'd4 - dbits));
      dsum = 5'({1'b0, s.dacc} + {1'b0, frac});
      req = 18'(base + {17'h0, (dbits != 3'd0) && ((dsum >> dbits) != 5'h0)});
      if (s.st == ST_RUN && s.cnt >= plen_m1) begin
         n.cur_lvl = cur;
         n.dacc = dsum[3:0] & dmask;
         if (req == 18'h0 || req >= MINP) begin
            n.on_len = req;
            n.skip_acc = 18'h0;
            n.skip_per = 8'h0;
         end else if (18'(s.skip_acc + req) >= MINP
                      || s.skip_per >= 8'((9'h1 << s.fsel) - 9'h1)) begin
            n.on_len = MINP;
            n.skip_acc = (18'(s.skip_acc + req) >= MINP) ? 18'(s.skip_acc + req - MINP) : 18'h0;
            n.skip_per = 8'h0;
         end else begin
            n.on_len = 18'h0;
            n.skip_acc = 18'(s.skip_acc + req);
            n.skip_per = 8'(s.skip_per + 8'h1);
         end
      end

      // Channel drive; direct mode bypasses the period entirely
      for (int c = 0; c < 6; c++) begin
         pos = 17'(s.cnt - s.phase[group_of(s.grp, 3'(c))]) & plen_m1;
         if (s.st != ST_RUN || !used_of(s.grp, 3'(c))) begin
            n.chan_en[c] = 1'b0;
         end else if (s.mode == MODE_DIRECT) begin
            n.chan_en[c] = pwm_in;
         end else begin
            n.chan_en[c] = {1'b0, pos} < s.on_len;
         end
      end
      if (s.mode == MODE_DIRECT) begin
         n.cur_lvl = 12'hFFF;
      end

      // Wishbone slave, one wait state, ack held a single cycle
      n.ack = wb_req.cyc && wb_req.stb && !s.ack;
      n.rdat = 32'h0;
      if (n.ack) begin
         wm = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}}, {8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};
         case (wb_req.adr)
            `ADR_CTRL: begin
               n.rdat = {22'h0, s.hyb_zero, s.dither_sel, s.slope_sel, s.curved, s.src_reg};
               if (wb_req.we) begin
                  wm = (n.rdat & ~wm) | (wb_req.dat & wm);
                  n.src_reg = wm[`CTRL_SRC];
                  n.curved = wm[`CTRL_CURVED];
                  n.slope_sel = wm[`CTRL_SLOPE_LO +: 3];
                  n.dither_sel = wm[`CTRL_DITHER_LO +: 4];
                  n.hyb_zero = wm[`CTRL_HYB_ZERO];
               end
            end
            `ADR_BRIGHT: begin
               n.rdat = {16'h0, s.bright_reg};
               if (wb_req.we) begin
                  wm = (n.rdat & ~wm) | (wb_req.dat & wm);
                  n.bright_reg = wm[15:0];
               end
            end
            `ADR_STATUS: n.rdat = {s.pwm_duty, s.level};
            `ADR_CONFIG: n.rdat = {20'h0, s.st == ST_RUN, s.faults, s.grp, s.fsel, s.mode};
            default: n.rdat = 32'h0;
         endcase
         if (wb_req.we) begin
            n.rdat = 32'h0;
         end
      end
   end

   // All state in one register; ce low freezes everything
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
         s.st <= ST_INIT;
         s.mode <= MODE_PHASE;
         s.fsel <= `FREQ_FALLBACK;
         s.curved <= 1'b1;
         s.slope_sel <= `SLOPE_RESET;
         s.dither_sel <= `DITHER_RESET;
         s.src_reg <= 1'b0;
      end else if (ce) begin
         s <= n;
      end
   end

   assign wb_ack = s.ack;
   assign wb_dat_o = s.rdat;
   assign channel_enable = s.chan_en;
   assign current_level = s.cur_lvl;
endmodule // led_dim_engine
`default_nettype wire

/* verif/led_dim_engine_props.sv */
// Concurrent checks on the ports of the dimming engine
`timescale 1ns/1ns
`default_nettype none
module led_dim_props (
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire led_dim_pkg::wb_req_t wb_req,
   input wire logic wb_ack,
   input wire logic [31:0] wb_dat_o,
   input wire led_dim_pkg::strap_t strap,
   input wire logic pwm_in,
   input wire logic [5:0] channel_enable,
   input wire logic [11:0] current_level
);
   import led_dim_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Straps only change under reset, so they describe the running layout
   wire logic two_ch = strap.grouping_ok && strap.grouping == 3'h4;
   wire logic direct2 = two_ch && strap.mode_ok && strap.mode == 2'h3;
   // A bus request the slave must take at this edge
   sequence s_take;
      ce && wb_req.cyc && wb_req.stb && !wb_ack;
   endsequence
   sequence s_rise;
      direct2 && $rose(pwm_in);
   endsequence
   sequence s_fall;
      direct2 && $fell(pwm_in);
   endsequence
   a_ack_one_wait: assert property (s_take |=> wb_ack)
      else $error("bus request not answered after one wait state");
   a_ack_pulse: assert property (wb_ack && ce |=> !wb_ack)
      else $error("bus ack longer than one cycle");
   a_ack_has_req: assert property ($rose(wb_ack) |-> $past(wb_req.cyc) && $past(wb_req.stb))
      else $error("bus ack without request");
   a_dat_idle_zero: assert property (!wb_ack |-> wb_dat_o == 32'h0)
      else $error("read data outside ack cycle");
   a_init_outs_off: assert property (!$past(resetn) |-> channel_enable == 6'h0 && current_level == 12'h0)
      else $error("outputs active during initialisation");
   a_direct_on: assert property (s_rise |-> ##[1:3] channel_enable == 6'h03)
      else $error("direct outputs missed input rise");
   a_direct_off: assert property (s_fall |-> ##[1:3] channel_enable == 6'h00)
      else $error("direct outputs missed input fall");
   a_unused_off: assert property (two_ch |-> channel_enable[5:2] == 4'h0)
      else $error("unused channel enabled");
   a_freeze_hold: assert property (!ce |=> $stable(channel_enable) && $stable(current_level) && $stable(wb_ack))
      else $error("state moved while clock enable low");
endmodule // led_dim_props
bind led_dim_engine led_dim_props props_u (.clk(clk), .resetn(resetn), .ce(ce), .wb_req(wb_req),
   .wb_ack(wb_ack), .wb_dat_o(wb_dat_o), .strap(strap), .pwm_in(pwm_in),
   .channel_enable(channel_enable), .current_level(current_level));
`default_nettype wire

/* verif/led_pwm_source.sv */
// Behavioural PWM brightness source driving the engine input pin
`timescale 1ns/1ns
`default_nettype none
module led_pwm_source (
   input wire logic clk,
   input wire logic run,
   input wire logic [19:0] on_clks,
   input wire logic [19:0] per_clks,
   output var logic pwm_out
);
   logic [19:0] pos = 20'h0;
   // Free-running period of its own, unrelated to the engine period
   always @(posedge clk) begin
      pos <= (!run || pos + 20'h1 >= per_clks) ? 20'h0 : pos + 20'h1;
      pwm_out <= run && pos < on_clks; // Held low while stopped
   end
   initial pwm_out = 1'b0;
endmodule // led_pwm_source
`default_nettype wire

/* verif/led_dimming_pwm_engine_tb_top.sv */
// Self-checking bench for the LED dimming engine
`timescale 1ns/1ns
`default_nettype none
module led_dimming_pwm_engine_tb_top;
   import led_dim_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic ce = 1'b1;
   logic run = 1'b0;
   logic [19:0] on_clks = 20'h200;
   logic [19:0] per_clks = 20'h400;
   wb_req_t wb_req = '0;
   strap_t strap = '0;
   logic wb_ack, pwm_in;
   logic [31:0] wb_dat_o, rq;
   logic [5:0] chan;
   logic [11:0] cur;
   int miscompares = 0;
   int samples_checked = 0;
   int hc [6];
   int v, n, b;
   // Short slope tick keeps ramps to a few hundred cycles
   led_dim_engine #(.SLOPE_TICK_CYC(4)) dut_u (.clk(clk), .resetn(resetn), .ce(ce),
      .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o), .strap(strap), .pwm_in(pwm_in),
      .channel_enable(chan), .current_level(cur));
   led_pwm_source src_u (.clk(clk), .run(run), .on_clks(on_clks), .per_clks(per_clks),
      .pwm_out(pwm_in));
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic complete_run();
      $display("compares %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   // Classic single cycle; held until ack, then released for one cycle
   task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
      int k;
      k = 0;
      wb_req <= {2'h3, we, a, 4'hF, d};
      do begin
         @(posedge clk);
         k++;
      end while (wb_ack !== 1'b1 && k < 50);
      if (k >= 50) miscompares++;
      rq = wb_dat_o;
      wb_req <= '0;
      @(posedge clk);
   endtask
   task automatic boot(input strap_t s);
      resetn <= 1'b0;
      strap <= s;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   // Fresh rising edge on channel 0, bounded both ways
   task automatic edge0();
      repeat (3000) begin
         @(posedge clk);
         if (chan[0] === 1'b0) break;
      end
      repeat (70000) begin
         @(posedge clk);
         if (chan[0] === 1'b1) break;
      end
   endtask
   task automatic measure(input int w);
      hc = '{default:0};
      repeat (w) begin
         for (int i = 0; i < 6; i++) hc[i] += chan[i];
         @(posedge clk);
      end
   endtask
   function automatic logic [31:0] cfg_exp(input strap_t s);
      logic [1:0] m;
      logic [2:0] f, g;
      m = s.mode_ok ? s.mode : 2'h0;
      f = s.freq_ok ? s.freq : 3'h1;
      g = s.grouping_ok ? s.grouping : 3'h0;
      return {20'h0, 1'b1, !s.grouping_ok, !s.mode_ok, !s.freq_ok, g, f, m};
   endfunction
   // Main sequence: phase-shift at 1024-clock period, then hybrid, then direct
   initial begin
      void'($urandom(5));
      boot({2'h0, 1'b1, 3'h7, 1'b1, 3'h0, 1'b1});
      bus(1'b0, 4'h0, 32'h0);
      check(rq, 32'h0000000E);
      bus(1'b0, 4'hC, 32'h0);
      check(rq, cfg_exp(strap));
      b = $urandom;
      bus(1'b1, 4'h4, b);
      bus(1'b0, 4'h4, 32'h0);
      check(rq, b & 32'hFFFF);
      bus(1'b1, 4'h1, b);
      bus(1'b0, 4'h1, 32'h0);
      check(rq, 32'h0);
      $display("registers done");
      bus(1'b1, 4'h0, 32'h1);
      bus(1'b1, 4'h4, 32'h0);
      bus(1'b1, 4'h0, 32'h5);
      bus(1'b1, 4'h4, 32'h8000);
      repeat (100) @(posedge clk);
      bus(1'b0, 4'h8, 32'h0);
      check(rq[15:0] > 16'h0 && rq[15:0] < 16'h8000, 32'h1);
      repeat (300) @(posedge clk);
      bus(1'b0, 4'h8, 32'h0);
      check(rq[15:0], 32'h8000);
      $display("sloper done");
      bus(1'b1, 4'h0, 32'h1);
      b = $urandom_range(16'hC000, 16'h1000);
      bus(1'b1, 4'h4, b);
      edge0();
      edge0();
      measure(1024);
      for (int i = 0; i < 6; i++) check(hc[i], b >> 6);
      edge0();
      n = 0;
      while (chan[1] !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      check(n, 32'hAA);
      $display("phase shift done");
      for (int k = 0; k < 5; k++) begin
         n = k < 4 ? k + 1 : 3;
         v = k < 4 ? $urandom_range((1 << n) - 1, 0) : 7;
         bus(1'b1, 4'h0, 32'h1 | (n << 5));
         bus(1'b1, 4'h4, 32'h8000 | (v << (6 - n)));
         edge0();
         edge0();
         measure(1024 << n);
         check(hc[0], (512 << n) + v);
      end
      bus(1'b1, 4'h0, 32'h1);
      bus(1'b1, 4'h4, 32'h40);
      edge0();
      edge0();
      measure(4096);
      check(hc[0], 32'h4);
      $display("dither done");
      // On-time steps of 0, 64 and 65 clocks around the accepted value
      bus(1'b1, 4'h0, 32'h0);
      for (int k = 0; k < 3; k++) begin
         on_clks <= 20'h200 + (k == 0 ? 0 : 63 + k);
         run <= 1'b1;
         repeat (3500) @(posedge clk);
         bus(1'b0, 4'h8, 32'h0);
         check(rq, k < 2 ? 32'h80008000 : 32'h90409040);
      end
      run <= 1'b0;
      $display("hysteresis done");
      boot({2'h1, 1'b1, 3'h7, 1'b1, 3'h0, 1'b1});
      for (int k = 0; k < 3; k++) begin
         b = k == 1 ? $urandom_range(16'hFFFF, 16'h2000) : 16'h1000;
         bus(1'b1, 4'h0, k == 2 ? 32'h201 : 32'h1);
         bus(1'b1, 4'h4, b);
         repeat (2400) begin
            @(posedge clk);
            ce <= ($urandom % 8) != 0;
         end
         ce <= 1'b1;
         check(cur, (k == 2 || b >= 16'h2000) ? b >> 4 : 32'h200);
         if (k == 0) begin
            edge0();
            measure(1024);
            check(hc[0], 32'h200);
         end
      end
      $display("hybrid done");
      boot({2'h3, 1'b1, 3'h7, 1'b0, 3'h4, 1'b1});
      bus(1'b0, 4'hC, 32'h0);
      check(rq, cfg_exp(strap));
      on_clks <= 20'h12C;
      per_clks <= 20'h2BC;
      run <= 1'b1;
      repeat (3000) @(posedge clk);
      check(cur, 32'hFFF);
      $display("direct done");
      complete_run();
   end
   // Hang guard only a little beyond the expected run length
   initial begin
      repeat (99000) @(posedge clk);
      miscompares++;
      complete_run();
   end
endmodule // led_dimming_pwm_engine_tb_top
`default_nettype wire
